// ==== ssr_host_model.sv ====
// Host model for the serial sample readout: drives select and serial clock, captures bits.
// Assumes an idle-high serial clock that stands still between frames.
`timescale 1ns/100ps
module ssr_host_model #(
  parameter int HALF_NS = 80
) (
  output logic o_cs_n,
  output logic o_sclk,
  input wire logic i_sdo,
  input wire logic i_oe,
  output logic [15:0] o_word
);
  logic last_bit; // Last level the device drove onto the wire.
  logic line; // Level the host sees on the serial wire.

  // The wire has no pull, so a released line shows the inverse of the last level.
  // This keeps a late release from passing for a valid zero.
  assign line = i_oe ? i_sdo : ~last_bit;

  // Track the last driven level of the wire.
  always @(i_sdo or i_oe) begin
    if (i_oe) begin
      last_bit = i_sdo;
    end
  end

  // Idle pins before the first frame.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_word = 16'h0000;
    last_bit = 1'b0;
  end

  // One frame of the given number of serial clock falls, then select rises.
  task automatic frame(input int falls);
    // select falls with the clock high.
    o_cs_n = 1'b0;
    #(HALF_NS);
    for (int k = 0; k < falls; k++) begin
      o_sclk = 1'b0;
      #(HALF_NS);
      o_sclk = 1'b1;
      o_word = {o_word[14:0], line};
      #(HALF_NS);
    end
    o_cs_n = 1'b1;
    #400;
  endtask : frame

  // One full frame whose select falls while the serial clock is low.
  // The first rising edge then catches the zero driven at the select fall.
  task automatic frame_early();
    o_sclk = 1'b0;
    #(HALF_NS);
    // select falls with the clock low.
    o_cs_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      #(HALF_NS);
      o_sclk = 1'b1;
      o_word = {o_word[14:0], line};
      #(HALF_NS);
      o_sclk = 1'b0;
    end
    // The sixteenth fall has just released the wire; this last rise is not captured.
    #(HALF_NS);
    o_sclk = 1'b1;
    #(HALF_NS);
    o_cs_n = 1'b1;
    #400;
  endtask : frame_early
endmodule : ssr_host_model

// ==== ssr_pkg.sv ====
// Package for the serial sample readout block: frame layout, edge counts, carriers.
// Assumes a single system clock domain; the serial clock and select are sampled pins.
package ssr_pkg;
  // Width of the conversion result and of the serial edge counters.
  localparam int RES_W = 8;
  localparam int CNT_W = 5;
  // Edge numbers counted from the select fall.
  localparam logic [4:0] FRAME_EDGES = 5'h10; // Falling edge that ends the frame.
  localparam logic [4:0] TRACK_RISE = 5'h0D; // Rising edge that returns to tracking.
  localparam logic [4:0] NOISE_EDGES = 5'h02; // Below this a select rise is noise.
  localparam logic [4:0] KEEP_EDGES = 5'h0A; // From this edge on the mode stays normal.
  localparam logic [4:0] FIRST_DATA = 5'h04; // Edge that carries the result MSB.
  localparam logic [4:0] LAST_DATA = 5'h0B; // Edge that carries the result LSB.
  localparam logic [4:0] LAST_TRIAL = 5'h08; // Edge that settles the result LSB.
  localparam logic [4:0] ONE_EDGE = 5'h01; // Counter step and first trial edge.
  // First trial word of the search: half scale.
  localparam logic [7:0] DAC_HALF = 8'h80;
  localparam logic [7:0] DAC_ZERO = 8'h00;
  // Depth of the result FIFO.
  localparam int FIFO_DEPTH = 8;

  // Operating modes of the converter.
  typedef enum logic {SSR_NORMAL, SSR_SHUTDOWN} ssr_mode_t;

  // One finished result as it travels through the FIFO.
  typedef struct packed {
    logic invalid;      // First result after leaving shutdown; discard it.
    logic [7:0] code;   // Straight binary code, one step is supply / 256.
  } ssr_result_t;
endpackage : ssr_pkg

// ==== ssr_readout.sv ====
// Serial sample readout: select and clock pin sampling, SAR sequencing, frame
// serializer, shutdown handling and a result FIFO toward local logic.
// Assumes the serial clock is far slower than i_clk_sys, so that every pin
// edge is seen after the two-flop synchroniser.
`timescale 1ns/100ps

// Small FIFO with valid and ready on both sides.
module ssr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage words and pointers; count tells full from empty honestly.
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];

  // Write side stores a word on every accepted push.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // Pointers wrap on the power-of-two depth.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= push ? wr_ff + AW'(1) : wr_ff;
      rd_ff <= pop ? rd_ff + AW'(1) : rd_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssr_fifo

// Notes on behaviour
// - Select fall samples input, starts conversion.
// - Count serial clock edges from select fall.
// - Search DAC word until comparator balances.
// - Return to tracking on 13th rising edge.
// - Output leaves high impedance at select fall.
// - Output floats after 16th fall or select rise.
// - Full frame takes sixteen serial clock cycles.
// - Bits change on falling clock edges.
// - Three zeros, eight bits MSB first, four zeros.
// - Early select fall may add leading zero.
// - Unsigned straight binary, step supply over 256.
// - Rise between edges two and ten: shutdown.
// - Rise between ten and sixteen: abort, stay normal.
// - Rise before second edge is ignored as noise.
// - First result after shutdown marked invalid.
module ssr_readout #(
  parameter int DEPTH = ssr_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_cmp_above,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_track,
  output logic [7:0] o_dac_word,
  output logic o_shutdown,
  output logic o_res_valid,
  input wire logic i_res_ready,
  output ssr_pkg::ssr_result_t o_res_data
);
  // Two-flop synchronisers for the pins; only the second stage is read.
  logic [1:0] cs_meta_ff, sclk_meta_ff, cmp_meta_ff;
  logic cs_q_ff; // Previous synchronised select, for edge detection.
  logic sclk_q_ff; // Previous synchronised clock, for edge detection.
  // Frame state.
  logic [4:0] fall_cnt_ff; // Falling serial edges since select fall.
  logic [4:0] rise_cnt_ff; // Rising serial edges since select fall.
  logic frame_ff; // A frame is open.
  logic woke_ff; // This frame started in shutdown.
  ssr_pkg::ssr_mode_t mode_ff;
  logic [7:0] dac_ff; // Trial word; final value is the result.
  logic sdo_ff, oe_ff, track_ff; // Serial bit, its pin enable, tracking flag.
  // Result waiting for the FIFO; held while the FIFO is full.
  logic pend_ff;
  ssr_pkg::ssr_result_t pend_data_ff;
  logic fifo_ready;
  wire cs_s = cs_meta_ff[1];
  wire sclk_s = sclk_meta_ff[1];
  wire cmp_s = cmp_meta_ff[1];
  wire cs_fall = cs_q_ff && !cs_s;
  wire cs_rise = !cs_q_ff && cs_s;
  wire sclk_fall = sclk_q_ff && !sclk_s && frame_ff && !cs_s;
  wire sclk_rise = !sclk_q_ff && sclk_s && frame_ff && !cs_s;
  // Saturating next counts; they stop at the frame end.
  wire fall_sat = (fall_cnt_ff == ssr_pkg::FRAME_EDGES);
  wire rise_sat = (rise_cnt_ff == ssr_pkg::FRAME_EDGES);
  wire [4:0] nxt_fall = fall_sat ? fall_cnt_ff : fall_cnt_ff + ssr_pkg::ONE_EDGE;
  wire [4:0] nxt_rise = rise_sat ? rise_cnt_ff : rise_cnt_ff + ssr_pkg::ONE_EDGE;
  // Successive approximation: the bit under trial moves down one per edge.
  wire sar_step = sclk_fall && (nxt_fall >= ssr_pkg::ONE_EDGE)
                  && (nxt_fall <= ssr_pkg::LAST_TRIAL);
  wire [7:0] trial_bit = ssr_pkg::DAC_HALF >> (nxt_fall - ssr_pkg::ONE_EDGE);
  wire [7:0] nxt_dac = (cmp_s ? dac_ff : (dac_ff & ~trial_bit)) | (trial_bit >> 1);
  // Serial bit for the new edge: data only in the eight data slots.
  wire in_data = (nxt_fall >= ssr_pkg::FIRST_DATA) && (nxt_fall <= ssr_pkg::LAST_DATA);
  wire [4:0] data_idx = ssr_pkg::LAST_DATA - nxt_fall;
  wire nxt_sdo = in_data ? dac_ff[data_idx[2:0]] : 1'b0;
  wire frame_end = sclk_fall && (nxt_fall == ssr_pkg::FRAME_EDGES) && !fall_sat;
  // Select rise classification by falling edges seen so far.
  wire rise_noise = (fall_cnt_ff < ssr_pkg::NOISE_EDGES);
  wire rise_early = (fall_cnt_ff < ssr_pkg::KEEP_EDGES);
  wire to_shutdown = cs_rise && frame_ff && ((woke_ff && rise_early)
                     || (!rise_noise && rise_early));

  // Pin synchronisers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cs_meta_ff <= 2'h3;
      sclk_meta_ff <= 2'h3;
      cmp_meta_ff <= 2'h0;
      cs_q_ff <= 1'b1;
      sclk_q_ff <= 1'b1;
    end else begin
      cs_meta_ff <= {cs_meta_ff[0], i_cs_n};
      sclk_meta_ff <= {sclk_meta_ff[0], i_sclk};
      cmp_meta_ff <= {cmp_meta_ff[0], i_cmp_above};
      cs_q_ff <= cs_s;
      sclk_q_ff <= sclk_s;
    end
  end

  // Edge counters, cleared while select is high and held at the frame end.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || cs_s) begin
      fall_cnt_ff <= '0;
      rise_cnt_ff <= '0;
    end else begin
      fall_cnt_ff <= sclk_fall ? nxt_fall : fall_cnt_ff;
      rise_cnt_ff <= sclk_rise ? nxt_rise : rise_cnt_ff;
    end
  end

  // Frame, hold and tracking state; a select rise ends the frame like reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || cs_rise) begin
      frame_ff <= 1'b0;
      track_ff <= 1'b1;
      woke_ff <= 1'b0;
    end else if (cs_fall) begin
      frame_ff <= 1'b1;
      track_ff <= 1'b0;
      woke_ff <= (mode_ff == ssr_pkg::SSR_SHUTDOWN);
    end else if (sclk_rise && nxt_rise == ssr_pkg::TRACK_RISE) begin
      track_ff <= 1'b1;
    end
  end

  // Operating mode: any select fall powers up, early rises shut down.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || cs_fall) begin
      mode_ff <= ssr_pkg::SSR_NORMAL;
    end else if (to_shutdown) begin
      // shutdown window; noise keeps mode; late rise stays normal
      mode_ff <= ssr_pkg::SSR_SHUTDOWN;
    end
  end

  // DAC trial word.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dac_ff <= ssr_pkg::DAC_ZERO;
    end else if (cs_fall) begin
      dac_ff <= ssr_pkg::DAC_HALF;
    end else if (sar_step) begin
      dac_ff <= nxt_dac;
    end
  end

  // Serial output and its enable.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || cs_rise || frame_end) begin
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (cs_fall) begin
      // drive at select fall; first slot is a zero
      sdo_ff <= 1'b0;
      oe_ff <= 1'b1;
    end else if (sclk_fall && !fall_sat) begin
      // change on falling edge; frame layout
      sdo_ff <= nxt_sdo;
    end
  end

  // Finished result waits here until the FIFO takes it.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pend_ff <= 1'b0;
      pend_data_ff <= '0;
    end else if (frame_end && (!pend_ff || fifo_ready)) begin
      // full frame delivers result; mark first after shutdown
      pend_ff <= 1'b1;
      pend_data_ff <= '{invalid: woke_ff, code: dac_ff};
    end else if (fifo_ready) begin
      pend_ff <= 1'b0;
    end
  end

  ssr_fifo #(
    .WIDTH($bits(ssr_pkg::ssr_result_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_in_valid(pend_ff),
    .o_in_ready(fifo_ready),
    .i_in_data(pend_data_ff),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(o_res_data)
  );
  assign o_serial_result_out = sdo_ff;
  assign o_serial_result_oe = oe_ff;
  assign o_track = track_ff;
  assign o_dac_word = dac_ff;
  assign o_shutdown = (mode_ff == ssr_pkg::SSR_SHUTDOWN);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_oe_on_fall: assert property (cs_fall |=> oe_ff && !sdo_ff)
    else $error("output not driven after select fall");
  a_oe_off_rise: assert property (cs_rise |=> !oe_ff)
    else $error("output still driven after select rise");
  a_oe_off_end: assert property (frame_end |=> !oe_ff ##1 !oe_ff)
    else $error("output still driven after frame end");
  a_hold_on_fall: assert property (cs_fall |=> !track_ff && dac_ff == ssr_pkg::DAC_HALF)
    else $error("hold not entered at select fall");
  a_track_13: assert property (sclk_rise && nxt_rise == ssr_pkg::TRACK_RISE |=> track_ff)
    else $error("tracking not resumed at rise 13");
  a_hold_before_13: assert property (frame_ff && !cs_s && rise_cnt_ff < ssr_pkg::TRACK_RISE
      && !cs_fall |-> !track_ff)
    else $error("tracking before rise 13");
  a_lead_zero: assert property (oe_ff && fall_cnt_ff < ssr_pkg::FIRST_DATA |-> !sdo_ff)
    else $error("leading bit not zero");
  a_trail_zero: assert property (oe_ff && fall_cnt_ff > ssr_pkg::LAST_DATA |-> !sdo_ff)
    else $error("trailing bit not zero");
  a_cnt_clear: assert property (cs_s |=> fall_cnt_ff == '0 && rise_cnt_ff == '0)
    else $error("counters not cleared");
  a_cnt_sat: assert property (fall_sat && !cs_s |=> fall_sat || cs_s)
    else $error("counter left saturation");
  a_sar_msb: assert property (sar_step && nxt_fall == ssr_pkg::ONE_EDGE
      |=> dac_ff[7] == $past(cmp_s) && dac_ff[6])
    else $error("MSB trial wrong");
  a_shut_win: assert property (cs_rise && frame_ff && !woke_ff
      && fall_cnt_ff >= ssr_pkg::NOISE_EDGES && fall_cnt_ff < ssr_pkg::KEEP_EDGES
      |=> o_shutdown)
    else $error("no shutdown in window");
  a_late_normal: assert property (cs_rise && fall_cnt_ff >= ssr_pkg::KEEP_EDGES
      && !o_shutdown |=> !o_shutdown)
    else $error("late rise changed mode");
  a_noise_keep: assert property (cs_rise && !woke_ff && rise_noise
      |=> o_shutdown == $past(o_shutdown))
    else $error("noise changed mode");
  a_invalid_mark: assert property (frame_end && !pend_ff
      |=> pend_ff && pend_data_ff.invalid == $past(woke_ff))
    else $error("result validity mark wrong");
  a_bit_on_fall: assert property (oe_ff && $changed(sdo_ff) && !$past(cs_fall)
      |-> $past(sclk_fall))
    else $error("bit changed without falling edge");
  c_full_frame: cover property (frame_end ##[1:300] o_res_valid);
  c_shutdown: cover property (to_shutdown);
  c_truncate: cover property (cs_rise && frame_ff && fall_cnt_ff == 5'h0C);
  c_fifo_full: cover property (pend_ff && !fifo_ready);
endmodule : ssr_readout

// ==== test_serial_sample_readout.sv ====
// Self-checking bench for the serial sample readout with a host model on the serial side.
// Assumes the design asserts its own rules internally; this bench judges the ports.
`timescale 1ns/100ps
module test_serial_sample_readout;
  logic clk_sys; // System clock, 100 MHz.
  logic rst_n; // Synchronous reset, active low.
  logic cs_n, sclk, cmp_above, res_ready, sdo, oe, track, shutdown, res_valid;
  logic [7:0] dac_word, vin; // Vin is the analog input expressed as a code.
  logic [15:0] word; // Bits the host captured in the last frame.
  ssr_pkg::ssr_result_t res_data;
  int mismatches, checks, cycles;

  ssr_readout ssr_readout_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_cmp_above(cmp_above), .o_serial_result_out(sdo),
    .o_serial_result_oe(oe), .o_track(track), .o_dac_word(dac_word), .o_shutdown(shutdown),
    .o_res_valid(res_valid), .i_res_ready(res_ready), .o_res_data(res_data));
  ssr_host_model ssr_host_model_i (.o_cs_n(cs_n), .o_sclk(sclk),
    .i_sdo(sdo), .i_oe(oe), .o_word(word));

  // Clock generator.
  always #5 clk_sys = ~clk_sys;

  // Ideal comparator: high while the input is at or above the trial word.
  always @(negedge clk_sys) cmp_above <= (vin >= dac_word);

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // Compare one value and count it.
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  // Take the head result and compare it.
  task automatic take(input logic inv, input logic [7:0] code);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (res_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check({7'h00, res_data}, {7'h00, inv, code}, "result word");
    res_ready = 1'b1;
    @(negedge clk_sys);
    res_ready = 1'b0;
  endtask : take

  // Watch tracking and the output enable after every serial clock rise.
  task automatic watch_frame();
    for (int k = 1; k <= 16; k++) begin
      @(posedge sclk);
      repeat (6) @(negedge clk_sys);
      check({15'h0000, track}, {15'h0000, k >= 13}, "track");
      check({15'h0000, oe}, {15'h0000, k < 16}, "output enable");
    end
  endtask : watch_frame

  // Full frames at the code extremes and two alternating patterns.
  task automatic full_frames();
    logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
    foreach (codes[i]) begin
      @(negedge clk_sys);
      vin = codes[i];
      fork
        ssr_host_model_i.frame(16);
        watch_frame();
      join
      // Three zeros, the code, four zeros, then the released wire read as the inverse.
      check(word, {3'h0, codes[i], 5'h01}, "frame bits");
      check({8'h00, dac_word}, {8'h00, codes[i]}, "final dac");
      take(1'b0, codes[i]);
    end
  endtask : full_frames

  // Select falls with the serial clock low: the host sees a fourth leading zero.
  task automatic early_select();
    @(negedge clk_sys);
    vin = 8'hC3;
    ssr_host_model_i.frame_early();
    check(word, {4'h0, 8'hC3, 4'h0}, "early frame bits");
    take(1'b0, 8'hC3);
  endtask : early_select

  // Select rises in each range of the fall count, then recovery from shutdown.
  task automatic aborts();
    ssr_host_model_i.frame(1);
    check({15'h0000, shutdown}, 16'h0000, "noise rise");
    ssr_host_model_i.frame(12);
    check({14'h0000, shutdown, oe}, 16'h0000, "late abort");
    ssr_host_model_i.frame(5);
    check({14'h0000, shutdown, oe}, 16'h0002, "enter shutdown");
    ssr_host_model_i.frame(9);
    check({15'h0000, shutdown}, 16'h0001, "stay shutdown");
    check({15'h0000, res_valid}, 16'h0000, "aborted frames");
    @(negedge clk_sys);
    vin = 8'h3C;
    ssr_host_model_i.frame(16);
    check({15'h0000, shutdown}, 16'h0000, "wake");
    take(1'b1, 8'h3C);
    ssr_host_model_i.frame(16);
    take(1'b0, 8'h3C);
  endtask : aborts

  // Fill the result buffer with the consumer stalled, then drain it.
  task automatic fill_fifo();
    @(negedge clk_sys);
    vin = 8'h81;
    repeat (10) ssr_host_model_i.frame(16);
    check({15'h0000, res_valid}, 16'h0001, "buffer full");
    // Eight stored words plus the one waiting; the tenth frame is dropped.
    repeat (9) take(1'b0, 8'h81);
    repeat (20) @(negedge clk_sys);
    check({15'h0000, res_valid}, 16'h0000, "buffer empty");
  endtask : fill_fifo

  // Report the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence: reset, idle values, then the scenarios.
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    res_ready = 1'b0;
    cmp_above = 1'b0;
    vin = 8'h00;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({13'h0000, track, oe, shutdown}, 16'h0004, "idle pins");
    full_frames();
    early_select();
    aborts();
    fill_fifo();
    stop_test();
  end
endmodule : test_serial_sample_readout
